// ==== rtl/btb_pkg.sv ====
// Package for the bus termination, breakpoint and bus error block
package btb_pkg;

  // CPU space identification
  localparam logic [2:0]  FC_CPU_SPACE    = 3'h7;
  localparam logic [3:0]  CPU_TYPE_BREAKPOINT_REQUEST   = 4'h0;
  localparam logic [3:0]  CPU_TYPE_LOW_POWER_STOP = 4'h3;
  localparam logic [2:0]  HW_BREAKPOINT_REQUEST_NUMBER  = 3'h7;
  localparam logic [19:0] LOW_POWER_STOP_ADDR     = 20'h3fffe;
  localparam logic [15:0] PRECHARGE_WORD  = 16'hffff;

  // Bus monitor: longest period in system clock cycles
  localparam int          BUS_MON_CYCLES  = 64;
  localparam logic [6:0]  BUS_MON_MAX     = 7'h40;

  // Exception vector numbers
  localparam logic [7:0]  VEC_BUS_ERROR   = 8'h02;
  localparam logic [7:0]  VEC_ILLEGAL     = 8'h04;
  localparam logic [7:0]  VEC_HW_BREAKPOINT_REQUEST     = 8'h0c;

  // Bus cycle kinds the core may request
  typedef enum logic [2:0] {
    BTB_REQ_NONE   = 3'b000,
    BTB_REQ_NORMAL = 3'b001,
    BTB_REQ_SW_BREAKPOINT_REQUEST = 3'b010,
    BTB_REQ_HW_BREAKPOINT_REQUEST = 3'b011,
    BTB_REQ_LOW_POWER_STOP = 3'b100
  } btb_req_t;

  // Outcome of a bus cycle
  typedef enum logic [1:0] {
    BTB_END_NORMAL = 2'b00,
    BTB_END_HALT   = 2'b01,
    BTB_END_BUS_ERROR_IN   = 2'b10,
    BTB_END_RETRY  = 2'b11
  } btb_end_t;

  // Main state machine
  typedef enum logic [2:0] {
    BTB_ST_IDLE    = 3'b000,
    BTB_ST_CYCLE   = 3'b001,
    BTB_ST_HALTED  = 3'b010,
    BTB_ST_RETRY   = 3'b011,
    BTB_ST_STOPPED = 3'b100,
    BTB_ST_DBLFLT  = 3'b101
  } btb_state_t;

  // Termination inputs from the external bus
  typedef struct packed {
    logic [1:0] data_size_ack_n;
    logic       autovector_ack_n;
    logic       bus_error_in_n;
    logic       halt_in_n;
  } btb_term_t;

  // Bus request from the core
  typedef struct packed {
    btb_req_t    kind;
    logic [23:0] addr;
    logic [2:0]  function_code;
    logic        prefetch;
    logic        rte_frame;
    logic        write;
    logic [15:0] wdata;
  } btb_cmd_t;

  // Completion report to the core
  typedef struct packed {
    logic        done;
    logic        data_valid;
    logic [15:0] rdata;
    logic        bus_error;
  } btb_resp_t;

  // Exception request to the core
  typedef struct packed {
    logic       take;
    logic [7:0] vector;
  } btb_exc_t;

endpackage

// ==== rtl/btb_bus_term.sv ====
// Bus termination, CPU space special cycles and bus error handling
`timescale 1ns/100ps

module btb_bus_term #(
  parameter logic [6:0] BUS_MON_PERIOD = btb_pkg::BUS_MON_MAX
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire btb_pkg::btb_cmd_t cmd_i,
  input  wire logic              cmd_valid_i,
  input  wire logic              instr_done_i,
  input  wire logic              handler_first_done_i,
  input  wire logic              pipeline_flush_i,
  input  wire logic              tagged_exec_i,
  input  wire logic [2:0]        sw_breakpoint_request_number_i,
  input  wire logic [2:0]        interrupt_priority_mask_i,
  input  wire logic [2:0]        interrupt_level_i,
  input  wire logic              breakpoint_request_n_i,
  input  wire btb_pkg::btb_term_t term_i,
  input  wire logic [15:0]       data_i,
  output logic                   cmd_ready_o,
  output btb_pkg::btb_resp_t     resp_o,
  output btb_pkg::btb_exc_t      exc_o,
  output logic                   breakpoint_request_insert_o,
  output logic                   double_fault_o,
  output logic                   low_power_stop_o,
  output logic [2:0]             stop_mask_o,
  output logic [23:0]            addr_o,
  output logic [2:0]             function_code_o,
  output logic                   address_strobe_n_o,
  output logic                   data_strobe_n_o,
  output logic                   write_n_o,
  output logic [15:0]            data_o,
  output logic                   data_oe_o,
  output logic                   halt_out_o,
  output logic                   halt_oe_o
);
  import btb_pkg::*;

  // Whole state of the block in one struct
  typedef struct packed {
    btb_state_t  st;
    btb_term_t   term_m;
    btb_term_t   term_s;
    logic        breakpoint_request_m;
    logic        breakpoint_request_s;
    logic        breakpoint_request_s_d;
    logic        breakpoint_request_pend;
    logic        breakpoint_request_tag;
    logic        breakpoint_request_operand;
    logic        hw_exc_pend;
    logic        bus_error_in_pend;
    logic        in_handler;
    logic        after_reset;
    logic        first_done;
    btb_cmd_t    cur;
    logic [6:0]  mon;
    logic        mon_bus_error_in;
    logic [2:0]  mask;
    logic        cmd_ready;
    btb_resp_t   resp;
    btb_exc_t    exc;
    logic        breakpoint_request_insert;
    logic        dbl;
    logic        lp;
    logic        as_n;
    logic        ds_n;
    logic [15:0] dout;
    logic        doe;
  } btb_regs_t;

  btb_regs_t r_r;
  btb_regs_t r_nxt;

  logic      ack_seen;
  logic      bus_error_in_seen;
  logic      halt_seen;

  // Decoded terminations from the second synchroniser stage, plus the bus monitor error
  assign ack_seen  = (r_r.term_s.data_size_ack_n != 2'h3) || !r_r.term_s.autovector_ack_n;
  assign bus_error_in_seen = !r_r.term_s.bus_error_in_n || r_r.mon_bus_error_in;
  assign halt_seen = !r_r.term_s.halt_in_n;

  // Next-state logic
  always_comb begin
    r_nxt = r_r;
    // Termination and breakpoint pins pass two flip-flops before any use
    r_nxt.term_m   = term_i;
    r_nxt.term_s   = r_r.term_m;
    r_nxt.breakpoint_request_m   = !breakpoint_request_n_i;
    r_nxt.breakpoint_request_s   = r_r.breakpoint_request_m;
    r_nxt.breakpoint_request_s_d = r_r.breakpoint_request_s;
    r_nxt.resp.done        = 1'b0;
    r_nxt.resp.data_valid  = 1'b0;
    r_nxt.resp.bus_error   = 1'b0;
    r_nxt.exc.take         = 1'b0;
    r_nxt.breakpoint_request_insert      = 1'b0;
    r_nxt.mon_bus_error_in         = 1'b0;

    // Hardware breakpoint edge waits for the next free bus slot
    if (r_r.breakpoint_request_s && !r_r.breakpoint_request_s_d) begin
      r_nxt.breakpoint_request_pend = 1'b1;
    end

    // Prefetch tag dies with a flush before the tagged instruction runs
    if (pipeline_flush_i) begin
      r_nxt.breakpoint_request_tag = 1'b0;
    end

    // Instruction boundary: breakpoint and bus error exceptions
    if (instr_done_i) begin
      r_nxt.after_reset = 1'b0;
      if (r_r.hw_exc_pend && (r_r.breakpoint_request_operand || (r_r.breakpoint_request_tag && tagged_exec_i))) begin
        r_nxt.exc.take     = 1'b1;
        r_nxt.exc.vector   = VEC_HW_BREAKPOINT_REQUEST;
        r_nxt.hw_exc_pend  = 1'b0;
        r_nxt.breakpoint_request_tag     = 1'b0;
        r_nxt.breakpoint_request_operand = 1'b0;
      end else if (r_r.bus_error_in_pend) begin
        // One exception however many errors the instruction met
        r_nxt.exc.take   = 1'b1;
        r_nxt.exc.vector = VEC_BUS_ERROR;
        r_nxt.bus_error_in_pend  = 1'b0;
        r_nxt.in_handler = 1'b1;
      end
    end
    if (!r_r.breakpoint_request_tag && !r_r.breakpoint_request_operand && r_r.hw_exc_pend && pipeline_flush_i) begin
      r_nxt.hw_exc_pend = 1'b0;
    end

    // Latched error is released by the handler's first instruction
    if (handler_first_done_i) begin
      r_nxt.in_handler = 1'b0;
    end

    case (r_r.st)
      BTB_ST_IDLE: begin
        r_nxt.cmd_ready = 1'b1;
        r_nxt.as_n      = 1'b1;
        r_nxt.ds_n      = 1'b1;
        r_nxt.doe       = 1'b0;
        if (r_r.breakpoint_request_pend) begin
          // Hardware breakpoint acknowledge: 00001e in CPU space
          r_nxt.breakpoint_request_pend              = 1'b0;
          r_nxt.cur                    = '0;
          r_nxt.cur.kind               = BTB_REQ_HW_BREAKPOINT_REQUEST;
          r_nxt.cur.addr[19:16]        = CPU_TYPE_BREAKPOINT_REQUEST;
          r_nxt.cur.addr[4:2]          = HW_BREAKPOINT_REQUEST_NUMBER;
          r_nxt.cur.addr[1]            = 1'b1;
          r_nxt.cur.function_code      = FC_CPU_SPACE;
          r_nxt.cur.prefetch           = cmd_valid_i && cmd_i.prefetch;
          r_nxt.cmd_ready              = 1'b0;
          r_nxt.st                     = BTB_ST_CYCLE;
          r_nxt.mon                    = '0;
        end else if (cmd_valid_i && r_r.cmd_ready) begin
          r_nxt.cur       = cmd_i;
          r_nxt.cmd_ready = 1'b0;
          r_nxt.mon       = '0;
          r_nxt.st        = BTB_ST_CYCLE;
          if (cmd_i.kind == BTB_REQ_SW_BREAKPOINT_REQUEST) begin
            r_nxt.cur.addr          = '0;
            r_nxt.cur.addr[19:16]   = CPU_TYPE_BREAKPOINT_REQUEST;
            r_nxt.cur.addr[4:2]     = sw_breakpoint_request_number_i;
            r_nxt.cur.addr[1]       = 1'b0;
            r_nxt.cur.function_code = FC_CPU_SPACE;
            r_nxt.cur.write         = 1'b0;
          end else if (cmd_i.kind == BTB_REQ_LOW_POWER_STOP) begin
            // Mask in low bits, upper data bits zero
            r_nxt.cur.addr          = {4'h0, LOW_POWER_STOP_ADDR};
            r_nxt.cur.function_code = FC_CPU_SPACE;
            r_nxt.cur.write         = 1'b1;
            r_nxt.cur.wdata         = {13'h0000, interrupt_priority_mask_i};
            r_nxt.mask              = interrupt_priority_mask_i;
          end
        end
      end

      BTB_ST_CYCLE: begin
        r_nxt.as_n = 1'b0;
        r_nxt.ds_n = 1'b0;
        r_nxt.doe  = r_r.cur.write;
        r_nxt.dout = r_r.cur.wdata;
        r_nxt.mon  = r_r.mon + 7'h01;
        // Bus monitor cannot be disabled; period set by BUS_MON_PERIOD, 64 clocks by default
        if (r_r.mon == BUS_MON_PERIOD - 7'h01) begin
          r_nxt.mon_bus_error_in = 1'b1;
        end
        if (r_r.cur.kind == BTB_REQ_LOW_POWER_STOP) begin
          // Internal acknowledge, fast write: the strobe is shown for one beat
          // so outside devices see the broadcast, but none has to answer it
          if (!r_r.as_n) begin
            r_nxt.as_n      = 1'b1;
            r_nxt.ds_n      = 1'b1;
            r_nxt.doe       = 1'b0;
            r_nxt.resp.done = 1'b1;
            r_nxt.lp        = 1'b1;
            r_nxt.st        = BTB_ST_STOPPED;
          end
        end else if (!r_r.as_n && (bus_error_in_seen || ack_seen || halt_seen)) begin
          // Decode only once the strobe has been out for a clock: before that
          // the synchroniser may still carry the previous cycle's answer,
          // which would end this cycle early
          if (bus_error_in_seen && halt_seen) begin
            // Retry: end the cycle and rerun after halt and bus error both drop
            r_nxt.as_n = 1'b1;
            r_nxt.ds_n = 1'b1;
            r_nxt.doe  = 1'b0;
            r_nxt.st   = BTB_ST_RETRY;
          end else if (bus_error_in_seen) begin
            r_nxt.as_n          = 1'b1;
            r_nxt.ds_n          = 1'b1;
            r_nxt.doe           = 1'b0;
            r_nxt.resp.done     = 1'b1;
            r_nxt.resp.bus_error = 1'b1;
            r_nxt.st            = BTB_ST_IDLE;
            if (r_r.cur.kind == BTB_REQ_SW_BREAKPOINT_REQUEST) begin
              r_nxt.exc.take   = 1'b1;
              r_nxt.exc.vector = VEC_ILLEGAL;
            end else if (r_r.cur.kind == BTB_REQ_HW_BREAKPOINT_REQUEST) begin
              r_nxt.hw_exc_pend  = 1'b1;
              r_nxt.breakpoint_request_tag     = r_r.cur.prefetch;
              r_nxt.breakpoint_request_operand = !r_r.cur.prefetch;
            end else if (r_r.in_handler || r_r.after_reset || r_r.cur.rte_frame) begin
              r_nxt.dbl = 1'b1;
              r_nxt.st  = BTB_ST_DBLFLT;
            end else begin
              r_nxt.bus_error_in_pend = 1'b1;
            end
            if (r_r.cur.prefetch && r_r.cur.kind == BTB_REQ_NORMAL) begin
              r_nxt.resp.rdata = PRECHARGE_WORD;
            end
          end else if (ack_seen) begin
            r_nxt.as_n      = 1'b1;
            r_nxt.ds_n      = 1'b1;
            r_nxt.doe       = 1'b0;
            r_nxt.resp.done = 1'b1;
            r_nxt.st        = halt_seen ? BTB_ST_HALTED : BTB_ST_IDLE;
            if (r_r.cur.kind == BTB_REQ_SW_BREAKPOINT_REQUEST) begin
              r_nxt.breakpoint_request_insert = 1'b1;
              r_nxt.resp.rdata  = data_i;
            end else if (r_r.cur.kind != BTB_REQ_HW_BREAKPOINT_REQUEST && !r_r.cur.write) begin
              r_nxt.resp.data_valid = 1'b1;
              r_nxt.resp.rdata      = data_i;
            end
          end
        end
      end

      BTB_ST_HALTED: begin
        // Halt-terminated cycle: wait for halt release
        if (!halt_seen) begin
          r_nxt.st = BTB_ST_IDLE;
        end
      end

      BTB_ST_RETRY: begin
        if (!halt_seen && !bus_error_in_seen) begin
          r_nxt.mon = '0;
          r_nxt.st  = BTB_ST_CYCLE;
        end
      end

      BTB_ST_STOPPED: begin
        // Wake only on an interrupt above the stored mask
        if (interrupt_level_i > r_r.mask) begin
          r_nxt.lp = 1'b0;
          r_nxt.st = BTB_ST_IDLE;
        end
      end

      BTB_ST_DBLFLT: begin
        // Only reset leaves this state; arbitration lives elsewhere
        r_nxt.dbl       = 1'b1;
        r_nxt.cmd_ready = 1'b0;
      end

      default: begin
        r_nxt.st = BTB_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_r             <= '0;
      r_r.st          <= BTB_ST_IDLE;
      r_r.term_m      <= '1;
      r_r.term_s      <= '1;
      r_r.after_reset <= 1'b1;
      r_r.as_n        <= 1'b1;
      r_r.ds_n        <= 1'b1;
      r_r.cur.write   <= 1'b0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from the state register
  assign cmd_ready_o        = r_r.cmd_ready;
  assign resp_o             = r_r.resp;
  assign exc_o              = r_r.exc;
  assign breakpoint_request_insert_o      = r_r.breakpoint_request_insert;
  assign double_fault_o     = r_r.dbl;
  assign low_power_stop_o   = r_r.lp;
  assign stop_mask_o        = r_r.mask;
  assign addr_o             = r_r.cur.addr;
  assign function_code_o    = r_r.cur.function_code;
  assign address_strobe_n_o = r_r.as_n;
  assign data_strobe_n_o    = r_r.ds_n;
  assign write_n_o          = !r_r.cur.write;
  assign data_o             = r_r.dout;
  assign data_oe_o          = r_r.doe;
  // Open-drain halt: drive low on double fault
  assign halt_out_o         = 1'b0;
  assign halt_oe_o          = r_r.dbl;

endmodule

// ==== testbench/btb_bus_term_chk.sv ====
// Checker on the ports of the bus termination block
`timescale 1ns/100ps
module btb_bus_term_chk import btb_pkg::*; #(
  parameter logic [6:0] BUS_MON_PERIOD = BUS_MON_MAX
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        instr_done_i,
  input wire logic [2:0]  interrupt_level_i,
  input wire btb_resp_t   resp_o,
  input wire btb_exc_t    exc_o,
  input wire logic        double_fault_o,
  input wire logic        halt_oe_o,
  input wire logic        low_power_stop_o,
  input wire logic [2:0]  stop_mask_o,
  input wire logic        breakpoint_request_insert_o,
  input wire logic [23:0] addr_o,
  input wire logic [2:0]  function_code_o,
  input wire logic        address_strobe_n_o,
  input wire logic        write_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] low_cnt_r;
  // Strobe-low length; a silent bus must be cut short by the monitor
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt_r <= 8'h00;
    else low_cnt_r <= address_strobe_n_o ? 8'h00 : low_cnt_r + 8'h01;
  end
  breakpoint_request_addr_a: assert property (
    !address_strobe_n_o && function_code_o == FC_CPU_SPACE && addr_o[19:16] == CPU_TYPE_BREAKPOINT_REQUEST
    |-> addr_o[23:5] == 19'h0 && !addr_o[0] && write_n_o
    && (!addr_o[1] || addr_o[4:2] == HW_BREAKPOINT_REQUEST_NUMBER)) else $error("bad breakpoint address");
  low_power_stop_addr_a: assert property (
    !address_strobe_n_o && function_code_o == FC_CPU_SPACE && addr_o[19:16] == CPU_TYPE_LOW_POWER_STOP
    |-> addr_o[19:0] == LOW_POWER_STOP_ADDR && !write_n_o) else $error("bad stop broadcast");
  stop_wake_a: assert property (
    low_power_stop_o && interrupt_level_i > stop_mask_o |-> ##[1:4] !low_power_stop_o)
    else $error("no wake from stop");
  bus_mon_a: assert property (
    low_cnt_r <= {1'b0, BUS_MON_PERIOD} + 8'h04) else $error("bus monitor too late");
  bus_error_in_nodata_a: assert property (
    resp_o.done && resp_o.bus_error |-> !resp_o.data_valid && !breakpoint_request_insert_o)
    else $error("data taken from errored cycle");
  dbl_halt_a: assert property (
    $rose(double_fault_o) |-> ##[0:2] halt_oe_o) else $error("halt not pulled");
  dbl_stay_a: assert property (
    double_fault_o |=> double_fault_o && address_strobe_n_o) else $error("left double fault");
  // The illegal-instruction exception of a refused breakpoint is immediate
  exc_bound_a: assert property (
    exc_o.take && exc_o.vector != VEC_ILLEGAL
    |-> instr_done_i || $past(instr_done_i) || $past(instr_done_i, 2)
    || $past(instr_done_i, 3)) else $error("exception off boundary");
  dbl_c: cover property ($rose(double_fault_o));
  stop_c: cover property ($fell(low_power_stop_o));
  exc_c: cover property (exc_o.take && exc_o.vector == VEC_HW_BREAKPOINT_REQUEST);
endmodule

// ==== testbench/btb_term_model.sv ====
// Far-side termination logic model for the external bus
`timescale 1ns/100ps
module btb_term_model import btb_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        address_strobe_n_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic [1:0]  delay_i,
  input  wire logic [15:0] rdata_i,
  output btb_term_t        term_o,
  output logic [15:0]      data_o
);
  logic [1:0] cnt_r;
  logic       hit_r;
  logic [2:0] hold_r;
  // Modes: 0 ack, 1 error, 2 error and halt, 3 halt and ack, 4 silent
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_o <= '1;
      cnt_r <= 2'h0;
      hit_r <= 1'b0;
      hold_r <= 3'h0;
      data_o <= 16'h0000;
    end else begin
      data_o <= hit_r ? data_o : ~data_o; // Undriven bus keeps no old value
      if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
      if (hold_r == 3'h1) term_o.halt_in_n <= 1'b1;
      if (!address_strobe_n_i && !hit_r) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == delay_i) begin
          hit_r <= 1'b1;
          data_o <= rdata_i;
          term_o.data_size_ack_n <= {2{!(mode_i == 3'h0 || mode_i == 3'h3)}};
          term_o.bus_error_in_n <= !(mode_i == 3'h1 || mode_i == 3'h2);
          term_o.halt_in_n <= !(mode_i == 3'h2 || mode_i == 3'h3);
        end
      end else if (address_strobe_n_i && hit_r) begin
        hit_r <= 1'b0;
        cnt_r <= 2'h0;
        term_o.data_size_ack_n <= 2'b11;
        term_o.bus_error_in_n <= 1'b1;
        term_o.halt_in_n <= (mode_i != 3'h3);
        hold_r <= (mode_i == 3'h3) ? 3'h6 : 3'h0; // Halt outlives the cycle
      end
    end
  end
endmodule

// ==== testbench/btb_bus_term_tb.sv ====
// Self-checking bench for the bus termination block
`timescale 1ns/100ps
module btb_bus_term_tb;
  import btb_pkg::*;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, instr_done_i = 1'b0;
  logic        handler_first_done_i = 1'b0, pipeline_flush_i = 1'b0, tagged_exec_i = 1'b0;
  logic        breakpoint_request_n_i = 1'b1, cmd_ready_o, breakpoint_request_insert_o, double_fault_o;
  logic        low_power_stop_o, address_strobe_n_o, data_strobe_n_o, write_n_o, data_oe_o;
  logic        halt_out_o, halt_oe_o, ins_seen, cap_wr;
  logic [2:0]  sw_breakpoint_request_number_i = 3'h0, interrupt_priority_mask_i = 3'h0, stop_mask_o;
  logic [2:0]  interrupt_level_i = 3'h0, function_code_o, cap_fc, mode = 3'h0;
  logic [1:0]  dly = 2'h0;
  logic [15:0] data_i, data_o, cap_data, rdat = 16'h0000;
  logic [23:0] addr_o, cap_addr;
  logic [7:0]  exc_vec;
  btb_cmd_t    cmd_i = '0;
  btb_term_t   term_i;
  btb_resp_t   resp_o, r;
  btb_exc_t    exc_o;
  int          n_mismatch = 0, n_tests = 0, seed = 2, as_falls = 0, exc_cnt = 0, i, j, k, e0;
  btb_bus_term #(.BUS_MON_PERIOD(7'h08)) dut_u (.*);
  btb_term_model pm_u (.clk_i, .rst_n_i, .address_strobe_n_i(address_strobe_n_o), .mode_i(mode),
                       .delay_i(dly), .rdata_i(rdat), .term_o(term_i), .data_o(data_i));
  initial forever #2.5 clk_i = ~clk_i;
  // Cycle snapshot and sticky event counts, taken where outputs are settled
  always @(negedge address_strobe_n_o) as_falls++;
  always @(negedge clk_i) begin
    if (address_strobe_n_o === 1'b0) {cap_addr, cap_fc, cap_wr, cap_data} =
      {addr_o, function_code_o, write_n_o, data_o};
    if (breakpoint_request_insert_o === 1'b1) ins_seen = 1'b1;
    if (exc_o.take === 1'b1) begin
      exc_cnt++;
      exc_vec = exc_o.vector;
    end
  end
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkv(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    $display("FAIL %s expected event seen timeout", nm);
    n_mismatch++;
    summarize();
  endtask
  // One request held until taken; the far side answers in mode md
  task automatic go(input logic [2:0] md, input btb_req_t kd, input logic [23:0] ad,
                    input logic [2:0] fc, input logic wr);
    logic [15:0] w;
    w = 16'($random(seed));
    @(posedge clk_i);
    {mode, dly, rdat} <= {md, 2'($random(seed)), w};
    {sw_breakpoint_request_number_i, interrupt_priority_mask_i} <= {ad[2:0], ad[2:0]};
    cmd_i <= '{kd, ad, fc, !wr, 1'b0, wr, w};
    cmd_valid_i <= 1'b1;
    ins_seen = 1'b0;
    @(negedge clk_i);
    for (k = 0; k < 50 && cmd_ready_o !== 1'b1; k++) @(negedge clk_i);
    if (k == 50) tmo("ready");
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    for (k = 0; k < 300 && resp_o.done !== 1'b1; k++) @(negedge clk_i);
    if (k == 300) tmo("done");
    r = resp_o;
    #1; // Let the negedge snapshot of this cycle settle first
  endtask
  // Ends an instruction; expects vector v, or no exception for 8'hff
  task automatic bound(input logic [7:0] v, input logic h);
    e0 = exc_cnt;
    @(posedge clk_i);
    {instr_done_i, tagged_exec_i} <= 2'b11;
    @(posedge clk_i);
    {instr_done_i, tagged_exec_i} <= 2'b00;
    repeat (12) @(negedge clk_i);
    chkv("exceptions", (v == 8'hff) ? 24'h0 : 24'h1, 24'(exc_cnt - e0));
    if (v != 8'hff) chkv("vector", 24'(v), 24'(exc_vec));
    @(posedge clk_i);
    handler_first_done_i <= h;
    @(posedge clk_i);
    handler_first_done_i <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bound(8'hff, 1'b0);
    for (i = 0; i < 12; i++) begin
      go(3'h0, BTB_REQ_NORMAL, 24'($random(seed)), {1'b0, 2'($random(seed))} + 3'h1,
         1'($random(seed)));
      chk1("error", 1'b0, r.bus_error);
      if (cap_wr === 1'b1) chkv("rdata", 24'(rdat), 24'(r.rdata));
      else chkv("wdata", 24'(rdat), 24'(cap_data));
    end
    for (i = 0; i < 8; i++) begin
      go(3'h0, BTB_REQ_SW_BREAKPOINT_REQUEST, 24'(i), FC_CPU_SPACE, 1'b0);
      chkv("breakpoint_request addr", 24'(i) << 2, cap_addr);
      chkv("breakpoint_request space", 24'(FC_CPU_SPACE), 24'(cap_fc));
      chk1("insert", 1'b1, ins_seen);
      chkv("insert word", 24'(rdat), 24'(r.rdata));
    end
    j = exc_cnt;
    go(3'h1, BTB_REQ_SW_BREAKPOINT_REQUEST, 24'h5, FC_CPU_SPACE, 1'b0);
    chkv("illegal count", 24'h1, 24'(exc_cnt - j));
    chkv("illegal vector", 24'(VEC_ILLEGAL), 24'(exc_vec));
    bound(8'hff, 1'b1);
    for (i = 0; i < 3; i++) begin
      go(3'h1, BTB_REQ_NORMAL, 24'h1000, 3'h6, 1'b0);
      chk1("bus_error_in", 1'b1, r.bus_error);
      chkv("precharge", 24'(PRECHARGE_WORD), 24'(r.rdata));
    end
    bound(VEC_BUS_ERROR, 1'b1);
    go(3'h4, BTB_REQ_NORMAL, 24'h2000, 3'h5, 1'b0);
    chk1("monitor", 1'b1, r.bus_error);
    bound(VEC_BUS_ERROR, 1'b1);
    chk1("no double", 1'b0, double_fault_o);
    j = as_falls;
    fork
      go(3'h2, BTB_REQ_NORMAL, 24'h3000, 3'h2, 1'b0);
      begin
        for (e0 = 0; e0 < 100 && term_i.bus_error_in_n !== 1'b0; e0++) @(negedge clk_i);
        if (e0 == 100) tmo("retry error");
        @(posedge clk_i);
        mode <= 3'h0;
      end
    join
    chkv("reruns", 24'h2, 24'(as_falls - j));
    chkv("rerun data", 24'(rdat), 24'(r.rdata));
    go(3'h3, BTB_REQ_NORMAL, 24'h4000, 3'h3, 1'b0);
    @(negedge clk_i);
    chk1("halted", 1'b0, cmd_ready_o);
    for (j = 0; j < 40 && cmd_ready_o !== 1'b1; j++) @(negedge clk_i);
    chk1("resumed", 1'b1, cmd_ready_o);
    if (j == 40) tmo("resume");
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i);
      {mode, breakpoint_request_n_i} <= {3'(1 - i), 1'b0};
      j = as_falls;
      for (k = 0; k < 100 && (as_falls == j || address_strobe_n_o !== 1'b1); k++)
        @(negedge clk_i);
      if (k == 100) tmo("hw cycle");
      @(posedge clk_i);
      breakpoint_request_n_i <= 1'b1;
      chkv("hw addr", 24'h00001e, cap_addr);
      bound(i ? 8'hff : VEC_HW_BREAKPOINT_REQUEST, 1'b1);
    end
    go(3'h4, BTB_REQ_LOW_POWER_STOP, 24'h3, FC_CPU_SPACE, 1'b1);
    chk1("stopped", 1'b1, low_power_stop_o);
    chkv("mask", 24'h3, 24'(stop_mask_o));
    chkv("stop addr", 24'(LOW_POWER_STOP_ADDR), 24'(cap_addr[19:0]));
    chkv("mask word", 24'h3, 24'(cap_data));
    chk1("stop write", 1'b0, cap_wr);
    for (i = 3; i < 5; i++) begin
      @(posedge clk_i);
      interrupt_level_i <= 3'(i);
      repeat (6) @(negedge clk_i);
      chk1("stop state", i == 3, low_power_stop_o);
    end
    go(3'h1, BTB_REQ_NORMAL, 24'h5000, 3'h1, 1'b0);
    bound(VEC_BUS_ERROR, 1'b0);
    go(3'h1, BTB_REQ_NORMAL, 24'h5002, 3'h1, 1'b0);
    repeat (4) @(negedge clk_i);
    chk1("double", 1'b1, double_fault_o);
    chk1("halt pull", 1'b1, halt_oe_o);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk1("restart", 1'b0, double_fault_o);
    go(3'h1, BTB_REQ_NORMAL, 24'h6000, 3'h1, 1'b0);
    repeat (4) @(negedge clk_i);
    chk1("early fault", 1'b1, double_fault_o);
    summarize();
  end
endmodule
bind btb_bus_term btb_bus_term_chk #(.BUS_MON_PERIOD(BUS_MON_PERIOD)) chk_u (.*);
